// >>> design/sdd_driver.sv
// Segment display driver: APB registers, frame timing, plane levels
// What this block does
// (RULE1) Base clock divided from reference clock
// (RULE2) Frame is duty-count base clock periods
// (RULE3) Low-current bit picks 37k or 146k
// (RULE4) Fast charge pulses high current per edge
// (RULE5) Pulse width base/32, /64 or /128
// (RULE6) Four-bit contrast code sets bias level
// (RULE7) Wait mode leaves waveforms running
// (RULE8) Software disables driver before low power
// (RULE9) Stop with oscillator kept keeps running
// (RULE10) Stop without oscillator halts the driver
// (RULE11) Stop leaves all registers unchanged
// (RULE12) External interrupt resumes halted driver
// (RULE13) Enable bit read/write, drives planes, reset clear
// (RULE14) Charge and current bits read/write, reset clear
// (RULE15) Shared pin is fourth backplane at quarter
// (RULE16) Thirty pins, two port group selects
// (RULE17) Duty code static, third, quarter, unused
// (RULE18) Disabled: all planes at supply, ladder off
// (RULE19) Segment bit one lights, two planes each
// (RULE20) Base clock select ratios, reset clears
// (RULE21) Frontplane phase follows segment bit
// (RULE22) Settings take effect at frame boundary; the enable bit and the SYS register bits act at once
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "sdd_regs.svh"
module sdd_driver
    import sdd_pkg::*;
#(
    parameter int unsigned RATIO_SHIFT = 0
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // Power modes
    input  wire logic            stopMode,
    input  wire logic            wakeIrq,
    // Panel planes and ladder
    output sdd_lvl_e  [2:0]      backplaneOut,
    output sdd_lvl_e             sharedPlaneOut,
    output sdd_lvl_e  [26:1]     frontplaneOut,
    output logic      [1:0]      portGroupSeg,
    output logic                 ladderOn,
    output logic                 ladderLowRes,
    output logic      [3:0]      contrastCode
);
    function automatic logic [16:0] divRatio(input logic [2:0] sel);
        case (sel)
            3'h0: divRatio = 17'h00080;
            3'h1: divRatio = 17'h00100;
            3'h2: divRatio = 17'h00200;
            3'h3: divRatio = 17'h00400;
            3'h4: divRatio = 17'h04000;
            3'h5: divRatio = 17'h08000;
            3'h6: divRatio = 17'h10000;
            default: divRatio = 17'h00080;
        endcase
    endfunction

    function automatic sdd_lvl_e bpLvl(input logic act, input logic ph);
        if (act) begin
            bpLvl = ph ? LV_TOP : LV_V3;
        end else begin
            bpLvl = ph ? LV_V2 : LV_V1;
        end
    endfunction

    function automatic sdd_lvl_e fpLvl(input logic on, input logic ph,
                                       input logic stat);
        if (on) begin
            fpLvl = ph ? LV_V3 : LV_TOP;
        end else if (stat) begin
            fpLvl = ph ? LV_TOP : LV_V3;
        end else begin
            fpLvl = ph ? LV_V1 : LV_V2;
        end
    endfunction

    logic [7:0]       ctrl_q;
    logic [7:0]       clk_q;
    logic [2:0]       sys_q;
    logic [7:0]       seg_q [`SDD_DATA_COUNT];
    sdd_cfg_s         cfg_q;
    sdd_state_e       state_q;
    sdd_state_e       state_d;
    logic [15:0]      cnt_q;
    logic             half_q;
    logic [1:0]       slot_q;
    logic [31:0]      prdata_q;
    logic             pready_q;
    logic             pslverr_q;
    sdd_lvl_e [3:0]   bp_d;
    sdd_lvl_e [26:0]  fp_d;
    sdd_lvl_e [2:0]   bp_q;
    sdd_lvl_e         shared_q;
    sdd_lvl_e [26:1]  fp_q;
    logic [1:0]       portSeg_q;
    logic             ladderOn_q;
    logic             lowRes_q;
    logic [3:0]       contrast_q;
    logic             acc;
    logic             wrEn;
    logic             isData;
    logic [3:0]       dataIdx;
    logic [31:0]      rdVal;
    logic             mapped;
    logic [16:0]      ratio;
    logic [15:0]      halfLen;
    logic [16:0]      pulseLen;
    logic [1:0]       lastSlot;
    logic             halfEnd;
    logic             frameEnd;
    logic             pulse;
    logic [4:0]       fIdx;

    assign acc     = psel & penable & pready_q;
    assign wrEn    = acc & pwrite & pstrb[0];
    assign isData  = (paddr >= `SDD_DATA_OFS) && (paddr <= `SDD_DATA_LAST)
                     && (paddr[1:0] == 2'h0);
    assign dataIdx = 4'((paddr - `SDD_DATA_OFS) >> 2);

    // Read decode
    always_comb begin
        rdVal  = 32'h00000000;
        mapped = 1'b1;
        case (paddr)
            `SDD_CTRL_OFS: rdVal[7:0] = ctrl_q;
            `SDD_CLK_OFS:  rdVal[7:0] = clk_q;
            `SDD_SYS_OFS:  rdVal[2:0] = sys_q;
            `SDD_STAT_OFS: rdVal[4:0] = {state_q, slot_q, half_q};
            default: begin
                if (isData) begin
                    rdVal[7:0] = seg_q[dataIdx];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // APB answer one wait state after setup
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            if (psel & penable & ~pready_q) begin
                prdata_q  <= pwrite ? 32'h00000000 : rdVal;
                pslverr_q <= ~mapped;
            end
        end
    end

    // Control registers; halt never touches them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= `SDD_CTRL_RST; // RULE13 RULE14
            clk_q  <= `SDD_CLK_RST; // RULE20
            sys_q  <= `SDD_SYS_RST;
        end else if (wrEn) begin // RULE11
            if (paddr == `SDD_CTRL_OFS) begin
                ctrl_q <= pwdata[7:0];
            end
            if (paddr == `SDD_CLK_OFS) begin
                clk_q <= pwdata[7:0];
            end
            if (paddr == `SDD_SYS_OFS) begin
                sys_q <= pwdata[2:0];
            end
        end
    end

    // Segment data, two frontplanes per word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `SDD_DATA_COUNT; i++) begin
                seg_q[i] <= 8'h00;
            end
        end else if (wrEn && isData) begin
            seg_q[dataIdx] <= pwdata[7:0]; // RULE19
        end
    end

    // Run, halt and off sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (ctrl_q[`SDD_CTRL_EN]) begin
                    state_d = ST_RUN; // RULE13
                end
            end
            ST_RUN: begin
                // Wait mode has no input here: the driver keeps running
                if (!ctrl_q[`SDD_CTRL_EN]) begin // RULE7
                    state_d = ST_OFF; // RULE8
                end else if (stopMode && !sys_q[`SDD_SYS_KEEP]) begin
                    state_d = ST_HALT; // RULE9 RULE10
                end
            end
            ST_HALT: begin
                if (!ctrl_q[`SDD_CTRL_EN]) begin
                    state_d = ST_OFF;
                end else if (wakeIrq) begin
                    state_d = ST_RUN; // RULE12
                end
            end
            default: state_d = ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Divider, half period and slot timing
    always_comb begin
        ratio    = divRatio(cfg_q.clkSel) >> RATIO_SHIFT; // RULE1 RULE20
        halfLen  = (ratio[16:1] == 16'h0000) ? 16'h0001 : ratio[16:1];
        pulseLen = ratio >> (`SDD_PULSE_SHIFT + // RULE5
                   ((cfg_q.width > 2'(`SDD_PULSE_MAXW)) ?
                    2'(`SDD_PULSE_MAXW) : cfg_q.width));
        if (pulseLen == 17'h00000) begin
            pulseLen = 17'h00001;
        end
        case (cfg_q.duty) // RULE17
            DUTY_THIRD:   lastSlot = 2'h2;
            DUTY_QUARTER: lastSlot = 2'h3;
            default:      lastSlot = 2'h0;
        endcase
        halfEnd  = (cnt_q == halfLen - 16'h0001);
        frameEnd = halfEnd && half_q && (slot_q == lastSlot); // RULE2
        pulse    = ({1'b0, cnt_q} < pulseLen);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q  <= 16'h0000;
            half_q <= 1'b0;
            slot_q <= 2'h0;
        end else if (state_q != ST_RUN) begin
            cnt_q  <= 16'h0000;
            half_q <= 1'b0;
            slot_q <= 2'h0;
        end else if (halfEnd) begin
            cnt_q  <= 16'h0000;
            half_q <= ~half_q;
            if (half_q) begin
                slot_q <= (slot_q == lastSlot) ? 2'h0 : slot_q + 2'h1;
            end
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Working copy of the settings, renewed between frames and on every cycle the driver is not running
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_q <= '0;
        end else if (state_q != ST_RUN || frameEnd) begin
            cfg_q <= {ctrl_q[7:5], ctrl_q[3:0], clk_q[6:0]}; // RULE22
        end
    end

    // Plane levels for the current slot and half
    always_comb begin
        fIdx = 5'h00;
        for (int b = 0; b < 4; b++) begin
            bp_d[b] = bpLvl(slot_q == 2'(b), ~half_q);
        end
        for (int f = 0; f < 27; f++) begin
            fIdx    = 5'(f);
            fp_d[f] = fpLvl(seg_q[fIdx[4:1]][{fIdx[0], slot_q}], // RULE21
                            ~half_q, cfg_q.duty == DUTY_STATIC);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bp_q     <= {3{LV_TOP}};
            shared_q <= LV_TOP;
            fp_q     <= {26{LV_TOP}};
        end else if (state_q != ST_RUN) begin
            bp_q     <= {3{LV_TOP}}; // RULE18
            shared_q <= LV_TOP;
            fp_q     <= {26{LV_TOP}};
        end else begin
            bp_q     <= bp_d[2:0];
            shared_q <= (cfg_q.duty == DUTY_QUARTER) ? // RULE15
                        bp_d[3] : fp_d[0];
            fp_q     <= fp_d[26:1];
            if (!sys_q[`SDD_SYS_PLO]) begin // RULE16
                fp_q[22:19] <= {4{LV_TOP}};
            end
            if (!sys_q[`SDD_SYS_PHI]) begin
                fp_q[26:23] <= {4{LV_TOP}};
            end
        end
    end

    // Ladder resistance, supply switch and contrast
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ladderOn_q <= 1'b0;
            lowRes_q   <= 1'b1;
            contrast_q <= 4'h0;
            portSeg_q  <= 2'h0;
        end else begin
            ladderOn_q <= (state_q == ST_RUN); // RULE18
            lowRes_q   <= !cfg_q.reduced || // RULE3
                          (cfg_q.quick && pulse); // RULE4
            contrast_q <= cfg_q.contrast; // RULE6
            portSeg_q  <= sys_q[`SDD_SYS_PHI:`SDD_SYS_PLO];
        end
    end

    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign backplaneOut   = bp_q;
    assign sharedPlaneOut = shared_q;
    assign frontplaneOut  = fp_q;
    assign portGroupSeg   = portSeg_q;
    assign ladderOn       = ladderOn_q;
    assign ladderLowRes   = lowRes_q;
    assign contrastCode   = contrast_q;

    blank_off_a: assert property (@(posedge clk_sys) // RULE18
        disable iff (rst)
        state_q != ST_RUN |=> bp_q == {3{LV_TOP}} && !ladderOn_q)
        else $error("planes not blank while stopped");
    full_res_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
        !cfg_q.reduced |=> lowRes_q)
        else $error("ladder not at low resistance");
    low_res_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
        cfg_q.reduced && !cfg_q.quick |=> !lowRes_q)
        else $error("ladder not at high resistance");
    charge_edge_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == ST_RUN && cfg_q.reduced && cfg_q.quick && // RULE4
        cnt_q == 16'h0000 && $stable(cfg_q) |=> lowRes_q)
        else $error("no charge pulse at edge");
    shared_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == ST_RUN && cfg_q.duty == DUTY_QUARTER // RULE15
        |=> shared_q == $past(bp_d[3]))
        else $error("shared pin not fourth backplane");
    halt_entry_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == ST_RUN && ctrl_q[7] && stopMode && // RULE10
        !sys_q[0] |=> state_q == ST_HALT ##1 bp_q == {3{LV_TOP}})
        else $error("stop did not halt driver");
    keep_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == ST_RUN && ctrl_q[7] && sys_q[0] // RULE9
        |=> state_q == ST_RUN)
        else $error("driver stopped with oscillator kept");
    wake_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == ST_HALT && ctrl_q[7] && wakeIrq // RULE12
        |=> state_q == ST_RUN)
        else $error("wake did not resume driver");
    halt_regs_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == ST_HALT && !wrEn |=> $stable(ctrl_q) // RULE11
        && $stable(clk_q))
        else $error("registers changed in halt");
    frame_cfg_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == ST_RUN && !frameEnd |=> $stable(cfg_q)) // RULE22
        else $error("settings changed inside frame");
endmodule

// >>> design/sdd_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef SDD_REGS_SVH
`define SDD_REGS_SVH
`define SDD_CTRL_OFS     8'h00
`define SDD_CLK_OFS      8'h04
`define SDD_SYS_OFS      8'h08
`define SDD_STAT_OFS     8'h0C
`define SDD_DATA_OFS     8'h10
`define SDD_DATA_LAST    8'h44
`define SDD_DATA_COUNT   14
`define SDD_CTRL_RST     8'h00
`define SDD_CLK_RST      8'h00
`define SDD_SYS_RST      3'h0
`define SDD_CTRL_EN      7
`define SDD_CTRL_QUICK   6
`define SDD_CTRL_REDUCE  5
`define SDD_CTRL_CONTR   3:0
`define SDD_CLK_WIDTH    6:5
`define SDD_CLK_DUTY     4:3
`define SDD_CLK_SEL      2:0
`define SDD_SYS_KEEP     0
`define SDD_SYS_PLO      1
`define SDD_SYS_PHI      2
`define SDD_PULSE_SHIFT  5
`define SDD_PULSE_MAXW   2
`endif

// >>> design/sdd_pkg.sv
// Types shared by the segment display driver
package sdd_pkg;
    typedef enum logic [1:0] {
        LV_V3  = 2'h0,
        LV_V2  = 2'h1,
        LV_V1  = 2'h2,
        LV_TOP = 2'h3
    } sdd_lvl_e;
    typedef enum logic [1:0] {
        DUTY_STATIC  = 2'h0,
        DUTY_THIRD   = 2'h1,
        DUTY_QUARTER = 2'h2,
        DUTY_NONE    = 2'h3
    } sdd_duty_e;
    typedef enum logic [1:0] {
        ST_OFF  = 2'h0,
        ST_RUN  = 2'h1,
        ST_HALT = 2'h3
    } sdd_state_e;
    typedef struct packed {
        logic       enable;
        logic       quick;
        logic       reduced;
        logic [3:0] contrast;
        logic [1:0] width;
        sdd_duty_e  duty;
        logic [2:0] clkSel;
    } sdd_cfg_s;
endpackage

// >>> tb/sdd_panel_model.sv
// Passive panel model: counts full-scale drive on one segment
`timescale 1ns/100ps
module sdd_panel_model
    import sdd_pkg::*;
(
    // Clock and control
    input  wire logic            clk_sys,
    input  wire logic            clearCount,
    // Planes from the driver
    input  wire sdd_lvl_e [2:0]  backplaneOut,
    input  wire sdd_lvl_e [26:1] frontplaneOut,
    // Observed drive
    output logic          [15:0] fullCount
);
    // Segment at backplane 0 and frontplane 1 sees full voltage
    always_ff @(posedge clk_sys) begin
        if (clearCount) begin
            fullCount <= 16'h0000;
        end else if ((backplaneOut[0] == LV_TOP
                && frontplaneOut[1] == LV_V3)
                || (backplaneOut[0] == LV_V3
                && frontplaneOut[1] == LV_TOP)) begin
            fullCount <= fullCount + 16'h0001;
        end
    end
endmodule

// >>> tb/segment_display_driver_test.sv
// Testbench of the segment display driver
`timescale 1ns/100ps
`include "sdd_regs.svh"
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errTotal++; \
    $display("ERROR at %0t: got %0h, expected %0h", $time, (a), (b)); end end
module segment_display_driver_test;
    import sdd_pkg::*;
    logic            clk_sys;
    logic            rst;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [7:0]      paddr;
    logic [31:0]     pwdata;
    logic [3:0]      pstrb;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            stopMode;
    logic            wakeIrq;
    sdd_lvl_e [2:0]  backplaneOut;
    sdd_lvl_e        sharedPlaneOut;
    sdd_lvl_e [26:1] frontplaneOut;
    logic [1:0]      portGroupSeg;
    logic            ladderOn;
    logic            ladderLowRes;
    logic [3:0]      contrastCode;
    logic            clearCount;
    logic [15:0]     fullCount;
    int              errTotal;
    int              nCompared;
    int              n;
    int              k;
    logic [31:0]     rd;
    logic            er;

    sdd_driver #(.RATIO_SHIFT(4)) sdd_driver_i (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stopMode(stopMode), .wakeIrq(wakeIrq),
        .backplaneOut(backplaneOut), .sharedPlaneOut(sharedPlaneOut),
        .frontplaneOut(frontplaneOut), .portGroupSeg(portGroupSeg),
        .ladderOn(ladderOn), .ladderLowRes(ladderLowRes),
        .contrastCode(contrastCode));

    sdd_panel_model sdd_panel_model_i (
        .clk_sys(clk_sys), .clearCount(clearCount),
        .backplaneOut(backplaneOut), .frontplaneOut(frontplaneOut),
        .fullCount(fullCount));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task wrapUp;
        $display("Compared %0d, errors %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask

    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            errTotal++;
            wrapUp();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task rdChk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
        `CHK(er, 1'b0)
    endtask

    // Edges until backplane 0 next rises to the top level
    task riseWait(output int c);
        logic p;
        p = (backplaneOut[0] === LV_TOP);
        for (c = 1; c < 9000; c++) begin
            @(posedge clk_sys);
            if (!p && backplaneOut[0] === LV_TOP) break;
            p = (backplaneOut[0] === LV_TOP);
        end
        if (c == 9000) begin
            errTotal++;
            wrapUp();
        end
    endtask

    // First rise may still belong to the old settings
    task frameLen(output int c);
        riseWait(c);
        riseWait(c);
        riseWait(c);
    endtask

    // Edges over a window where the chosen output is asserted
    task cnt(input int c, input int s, output int h);
        h = 0;
        repeat (c) begin
            @(posedge clk_sys);
            case (s)
                0: h += (ladderLowRes === 1'b1);
                1: h += (sharedPlaneOut === LV_TOP);
                2: h += (frontplaneOut[19] === LV_TOP);
                default: h += (frontplaneOut[23] === LV_TOP);
            endcase
        end
    endtask

    task segCount(input int c, input int e);
        @(posedge clk_sys);
        clearCount <= 1'b1;
        @(posedge clk_sys);
        clearCount <= 1'b0;
        cyc(c);
        #1;
        `CHK(int'(fullCount), e)
    endtask

    initial begin
        errTotal = 0;
        nCompared = 0;
        rst = 1'b1;
        {psel, penable, pwrite, stopMode, wakeIrq, clearCount} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        cyc(2);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK(ladderOn, 1'b0)
        `CHK(backplaneOut[0], LV_TOP)
        `CHK(portGroupSeg, 2'h0)
        rdChk(`SDD_CTRL_OFS, 32'h00000000);
        rdChk(`SDD_CLK_OFS, 32'h00000000);
        wr(`SDD_CTRL_OFS, 8'h6A);
        rdChk(`SDD_CTRL_OFS, 32'h0000006A);
        apb(1'b0, 8'h80, 32'h00000000);
        `CHK({er, rd}, 33'h100000000)
        wr(`SDD_DATA_OFS, 8'h10);
        wr(`SDD_CLK_OFS, 8'h08);
        wr(`SDD_CTRL_OFS, 8'h80);
        cyc(4);
        `CHK(ladderOn, 1'b1)
        frameLen(n);
        `CHK(n, 24)
        segCount(24, 8);
        cnt(24, 1, k);
        `CHK(k, 0)
        cnt(24, 2, k);
        `CHK(k, 24)
        wr(`SDD_SYS_OFS, 8'h06);
        cyc(2);
        `CHK(portGroupSeg, 2'h3)
        cnt(24, 3, k);
        `CHK(k, 0)
        wr(`SDD_DATA_OFS, 8'h00);
        segCount(24, 0);
        wr(`SDD_CLK_OFS, 8'h10);
        frameLen(n);
        `CHK(n, 32)
        cnt(32, 1, k);
        `CHK(k, 4)
        for (int s = 0; s < 7; s++) begin
            wr(`SDD_CLK_OFS, 8'(s));
            frameLen(n);
            `CHK(n, (s < 4 ? 128 << s : 16384 << (s - 4)) >> 4)
        end
        for (int w = 0; w < 3; w++) begin
            wr(`SDD_CLK_OFS, 8'(w * 32 + 4));
            wr(`SDD_CTRL_OFS, 8'hE0);
            cyc(4200);
            cnt(1024, 0, k);
            `CHK(k, 64 >> w)
        end
        wr(`SDD_CTRL_OFS, 8'hC0);
        cyc(2100);
        cnt(1024, 0, k);
        `CHK(k, 1024)
        riseWait(n);
        wr(`SDD_CTRL_OFS, 8'hAF);
        `CHK(contrastCode, 4'h0)
        cyc(1100);
        `CHK(contrastCode, 4'hF)
        cnt(1024, 0, k);
        `CHK(k, 0)
        wr(`SDD_CLK_OFS, 8'h08);
        cyc(2100);
        stopMode <= 1'b1;
        cyc(3);
        `CHK({ladderOn, backplaneOut[0]}, {1'b0, LV_TOP})
        rdChk(`SDD_CTRL_OFS, 32'h000000AF);
        stopMode <= 1'b0;
        wakeIrq <= 1'b1;
        @(posedge clk_sys);
        wakeIrq <= 1'b0;
        cyc(3);
        `CHK(ladderOn, 1'b1)
        frameLen(n);
        `CHK(n, 24)
        wr(`SDD_SYS_OFS, 8'h07);
        stopMode <= 1'b1;
        cyc(3);
        `CHK(ladderOn, 1'b1)
        frameLen(n);
        `CHK(n, 24)
        stopMode <= 1'b0;
        wr(`SDD_CTRL_OFS, 8'h00);
        cyc(3);
        `CHK(ladderOn, 1'b0)
        `CHK({frontplaneOut[1], backplaneOut[1]}, {LV_TOP, LV_TOP})
        wrapUp();
    end
endmodule
